// *** verilog/cwal_alarm_logic.sv ***
// park brake alarm and exterior lamp reminder with an apb register file
// assumes switch inputs synchronous to clock, debounced outside the block
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none
module cwal_alarm_logic
    import cwal_pkg::*;
#(
    parameter int TICK_PERIOD = TICK_CYCLES,
    parameter int BEEP_ON     = BEEP_ON_CYCLES,
    parameter int BEEP_OFF    = BEEP_OFF_CYCLES
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rst,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // vehicle switches
    input  wire cwal_switches_type switches,
    // sounders and interrupt
    output logic                   horn,
    output logic                   buzzer,
    output logic                   irq
);
    // settings
    logic                    alarmNeedsKeyOff;
    logic                    lampWarnEnable;
    logic [7:0]              durationSec;
    logic [7:0]              suspendSec;
    logic [EVENTS_WIDTH-1:0] irqStatus;
    logic [EVENTS_WIDTH-1:0] irqMask;
    logic [EVENTS_WIDTH-1:0] events;
    // alarm state
    cwal_alarm_type          alarmState;
    logic [7:0]              alarmSeconds;
    logic [7:0]              suspendSeconds;
    // lamp state
    cwal_lamp_type           lampState;
    logic [31:0]             beepTimer;
    logic [2:0]              beepsDone;
    logic                    tick;

    // apb strobes
    logic writeAccess;
    logic readAccess;
    logic unmapped;
    assign writeAccess = psel && penable && pwrite;
    assign readAccess  = psel && penable && !pwrite;
    assign pready      = 1'b1;      // zero wait states

    // settings clamp to their documented range on write
    function automatic logic [7:0] clampTo(input logic [7:0] value,
                                           input logic [7:0] limit);
        clampTo = (value > limit) ? limit : value;
    endfunction

    // one second enable shared by both counters
    cwal_tick_divider #(
        .PERIOD (TICK_PERIOD)
    ) secondTick (
        .clock  (clock),
        .rst    (rst),
        .tick   (tick)
    );

    // address decode
    always_comb begin
        if (paddr == ADDR_CONTROL) begin
            unmapped = 1'b0;
        end else if (paddr == ADDR_DURATION) begin
            unmapped = 1'b0;
        end else if (paddr == ADDR_SUSPEND) begin
            unmapped = 1'b0;
        end else if (paddr == ADDR_STATUS) begin
            unmapped = 1'b0;
        end else if (paddr == ADDR_IRQ_STAT) begin
            unmapped = 1'b0;
        end else if (paddr == ADDR_IRQ_MASK) begin
            unmapped = 1'b0;
        end else begin
            unmapped = 1'b1;
        end
    end
    assign pslverr = psel && penable && unmapped;

    // setting registers; suspend is floored to a 10 s step
    always_ff @(posedge clock) begin
        if (rst) begin
            alarmNeedsKeyOff <= KEY_OFF_DEFAULT;
            lampWarnEnable   <= LAMP_WARN_DEFAULT;
            durationSec      <= DURATION_DEFAULT;
            suspendSec       <= SUSPEND_DEFAULT;
            irqMask          <= MASK_RESET;
        end else if (writeAccess) begin
            if (paddr == ADDR_CONTROL) begin
                alarmNeedsKeyOff <= pwdata[CTRL_KEY_OFF_BIT];
                lampWarnEnable   <= pwdata[CTRL_LAMP_WARN_BIT];
            end else if (paddr == ADDR_DURATION) begin
                durationSec <= clampTo(pwdata[7:0], DURATION_MAX);
            end else if (paddr == ADDR_SUSPEND) begin
                suspendSec <= clampTo(pwdata[7:0], SUSPEND_MAX)
                              / SUSPEND_STEP * SUSPEND_STEP;
            end else if (paddr == ADDR_IRQ_MASK) begin
                irqMask <= pwdata[EVENTS_WIDTH-1:0];
            end
        end
    end

    // read mux registered into prdata in the setup phase, ready for the access phase
    always_ff @(posedge clock) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == ADDR_CONTROL) begin
                prdata <= {30'h0, lampWarnEnable, alarmNeedsKeyOff};
            end else if (paddr == ADDR_DURATION) begin
                prdata <= {24'h00_0000, durationSec};
            end else if (paddr == ADDR_SUSPEND) begin
                prdata <= {24'h00_0000, suspendSec};
            end else if (paddr == ADDR_STATUS) begin
                prdata <= {16'h0000, lampState, alarmState, 6'h00,
                           buzzer, horn};
            end else if (paddr == ADDR_IRQ_STAT) begin
                prdata <= {28'h000_0000, irqStatus};
            end else if (paddr == ADDR_IRQ_MASK) begin
                prdata <= {28'h000_0000, irqMask};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // trigger conditions
    logic keyCondition;
    logic alarmTrigger;
    logic alarmClear;
    logic lampsOn;
    logic lampWarn;
    assign keyCondition = !alarmNeedsKeyOff || !switches.ignitionOn;
    assign alarmTrigger = keyCondition && !switches.parkBrakeSet
                          && switches.doorOpen;
    assign alarmClear   = switches.ignitionOn && switches.parkBrakeSet;
    assign lampsOn      = switches.headlights || switches.parkLights;
    assign lampWarn     = lampWarnEnable && lampsOn
                          && !switches.ignitionOn;

    // park brake alarm; done waits for the clear so it does not retrigger
    always_ff @(posedge clock) begin
        if (rst) begin
            alarmState     <= ALARM_IDLE;
            alarmSeconds   <= 8'h00;
            suspendSeconds <= 8'h00;
        end else begin
            case (alarmState)
                ALARM_IDLE: begin
                    alarmSeconds <= 8'h00;
                    if (alarmTrigger && durationSec != 8'h00) begin
                        alarmState <= ALARM_SOUND;
                    end
                end
                ALARM_SOUND: begin
                    if (alarmClear) begin
                        alarmState <= ALARM_IDLE;
                    end else if (switches.brakePedal) begin
                        alarmState     <= ALARM_SUSPEND;
                        suspendSeconds <= 8'h00;
                    end else if (alarmSeconds >= durationSec) begin
                        alarmState <= ALARM_DONE;
                    end else if (tick) begin
                        alarmSeconds <= alarmSeconds + 8'h01;
                    end
                end
                ALARM_SUSPEND: begin
                    if (alarmClear) begin
                        alarmState <= ALARM_IDLE;
                    end else if (switches.brakePedal) begin
                        suspendSeconds <= 8'h00;        // a new press restarts
                    end else if (suspendSeconds >= suspendSec) begin
                        // resume only while the conditions still hold
                        alarmState <= alarmTrigger ? ALARM_SOUND
                                                   : ALARM_DONE;
                    end else if (tick) begin
                        suspendSeconds <= suspendSeconds + 8'h01;
                    end
                end
                ALARM_DONE: begin
                    if (alarmClear) begin
                        alarmState <= ALARM_IDLE;
                    end
                end
                default: alarmState <= ALARM_IDLE;
            endcase
        end
    end

    // lamp reminder beep sequencer
    always_ff @(posedge clock) begin
        if (rst) begin
            lampState <= LAMP_IDLE;
            beepTimer <= 32'h0000_0000;
            beepsDone <= 3'h0;
        end else if (!lampWarn) begin
            lampState <= LAMP_IDLE;
            beepTimer <= 32'h0000_0000;
            beepsDone <= 3'h0;
        end else begin
            case (lampState)
                LAMP_IDLE: begin
                    lampState <= LAMP_BEEP;
                    beepTimer <= 32'h0000_0000;
                end
                LAMP_BEEP: begin
                    if (beepTimer == 32'(BEEP_ON - 1)) begin
                        beepTimer <= 32'h0000_0000;
                        beepsDone <= beepsDone + 3'h1;
                        lampState <= LAMP_GAP;
                    end else begin
                        beepTimer <= beepTimer + 32'h0000_0001;
                    end
                end
                LAMP_GAP: begin
                    if (beepsDone == 3'(BEEP_COUNT)) begin
                        lampState <= LAMP_QUIET;
                    end else if (beepTimer == 32'(BEEP_OFF - 1)) begin
                        beepTimer <= 32'h0000_0000;
                        lampState <= LAMP_BEEP;
                    end else begin
                        beepTimer <= beepTimer + 32'h0000_0001;
                    end
                end
                LAMP_QUIET: lampState <= LAMP_QUIET; // lamps off rearms
                default:    lampState <= LAMP_IDLE;
            endcase
        end
    end

    // sounders from flip-flops
    always_ff @(posedge clock) begin
        if (rst) begin
            horn   <= 1'b0;
            buzzer <= 1'b0;
        end else begin
            horn   <= (alarmState == ALARM_SOUND)
                      && !switches.brakePedal;
            buzzer <= lampWarn && (switches.doorOpen
                      || (lampState == LAMP_BEEP));
        end
    end

    // event pulses for the interrupt status
    logic lampWarnLast;
    cwal_alarm_type alarmLast;
    always_ff @(posedge clock) begin
        if (rst) begin
            lampWarnLast <= 1'b0;
            alarmLast    <= ALARM_IDLE;
        end else begin
            lampWarnLast <= lampWarn;
            alarmLast    <= alarmState;
        end
    end
    assign events[EV_ALARM_START]   = (alarmState == ALARM_SOUND)
                                      && (alarmLast == ALARM_IDLE);
    assign events[EV_ALARM_TIMEOUT] = (alarmState == ALARM_DONE)
                                      && (alarmLast != ALARM_DONE);
    assign events[EV_ALARM_CLEARED] = (alarmState == ALARM_IDLE)
                                      && (alarmLast != ALARM_IDLE);
    assign events[EV_LAMP_WARN]     = lampWarn && !lampWarnLast;

    // sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge clock) begin
        if (rst) begin
            irqStatus <= 4'h0;
        end else if (writeAccess && paddr == ADDR_IRQ_STAT) begin
            irqStatus <= (irqStatus & ~pwdata[EVENTS_WIDTH-1:0]) | events;
        end else begin
            irqStatus <= irqStatus | events;
        end
    end

    // level interrupt
    always_ff @(posedge clock) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStatus & irqMask);
        end
    end
endmodule
`default_nettype wire

// *** inc/cwal_pkg.sv ***
// package for the cab warning alarm logic: timing, defaults, apb map, types
// assumes a single 250 MHz clock and an apb master with 32-bit data
package cwal_pkg;

    // clock and time base
    localparam int CLOCK_HZ          = 250_000_000;
    localparam int TICK_SECONDS      = 1;
    localparam int TICK_CYCLES       = CLOCK_HZ * TICK_SECONDS;
    // beep cadence of the lamp reminder, in milliseconds
    localparam int BEEP_ON_MS        = 250;
    localparam int BEEP_OFF_MS       = 250;
    localparam int BEEP_ON_CYCLES    = (CLOCK_HZ / 1000) * BEEP_ON_MS;
    localparam int BEEP_OFF_CYCLES   = (CLOCK_HZ / 1000) * BEEP_OFF_MS;
    localparam int BEEP_COUNT        = 5;

    // settings: defaults and limits (seconds)
    localparam logic [7:0] DURATION_DEFAULT = 8'h3c;   // 60 s
    localparam logic [7:0] DURATION_MAX     = 8'hb4;   // 180 s
    localparam logic [7:0] SUSPEND_DEFAULT  = 8'h0a;   // 10 s
    localparam logic [7:0] SUSPEND_MAX      = 8'h3c;   // 60 s
    localparam logic [7:0] SUSPEND_STEP     = 8'h0a;   // 10 s steps
    localparam logic       KEY_OFF_DEFAULT  = 1'b1;
    localparam logic       LAMP_WARN_DEFAULT = 1'b1;

    // apb register byte addresses
    localparam logic [7:0] ADDR_CONTROL  = 8'h00;
    localparam logic [7:0] ADDR_DURATION = 8'h04;
    localparam logic [7:0] ADDR_SUSPEND  = 8'h08;
    localparam logic [7:0] ADDR_STATUS   = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

    // control register fields
    localparam int CTRL_KEY_OFF_BIT   = 0;
    localparam int CTRL_LAMP_WARN_BIT = 1;

    // event bits, shared by irq status and mask
    localparam int EVENTS_WIDTH       = 4;
    localparam int EV_ALARM_START     = 0;
    localparam int EV_ALARM_TIMEOUT   = 1;
    localparam int EV_ALARM_CLEARED   = 2;
    localparam int EV_LAMP_WARN       = 3;
    localparam logic [3:0] MASK_RESET = 4'h0;

    // vehicle switch inputs
    typedef struct packed {
        logic ignitionOn;    // run or accessory
        logic parkBrakeSet;
        logic brakePedal;
        logic doorOpen;
        logic headlights;
        logic parkLights;
    } cwal_switches_type;

    // park brake alarm states
    typedef enum logic [3:0] {
        ALARM_IDLE    = 4'b0001,
        ALARM_SOUND   = 4'b0010,
        ALARM_SUSPEND = 4'b0100,
        ALARM_DONE    = 4'b1000
    } cwal_alarm_type;

    // lamp reminder states
    typedef enum logic [3:0] {
        LAMP_IDLE  = 4'b0001,
        LAMP_BEEP  = 4'b0010,
        LAMP_GAP   = 4'b0100,
        LAMP_QUIET = 4'b1000
    } cwal_lamp_type;

endpackage

// *** verilog/cwal_tick_divider.sv ***
// divider giving a one-cycle enable pulse every PERIOD clock cycles
// assumes one clock; reset is synchronous and active high
`timescale 1ns/100ps
`default_nettype none
module cwal_tick_divider #(
    parameter int PERIOD = 250_000_000
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // enable pulse
    output logic      tick
);
    logic [31:0] count;

    // free running count, pulse on the wrap
    always_ff @(posedge clock) begin
        if (rst) begin
            count <= 32'h0000_0000;
            tick  <= 1'b0;
        end else if (count == 32'(PERIOD - 1)) begin
            count <= 32'h0000_0000;
            tick  <= 1'b1;
        end else begin
            count <= count + 32'h0000_0001;
            tick  <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** bench/cwal_alarm_chk.sv ***
// checker for the cab warning alarm block, watching its ports only
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module cwal_alarm_chk
    import cwal_pkg::*;
#(
    parameter int TICK_PERIOD = 10
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rst,
    // switches and sounders
    input  wire cwal_switches_type switches,
    input  wire logic              horn,
    input  wire logic              buzzer
);
    int unsigned hornRun;
    logic        lampHold;
    // door open with lamps on and key off: the buzzer may not drop out
    assign lampHold = switches.doorOpen && !switches.ignitionOn
                   && (switches.headlights || switches.parkLights);
    // length of the current horn run, cleared whenever the horn is quiet
    always_ff @(posedge clock) begin
        if (rst || !horn) begin
            hornRun <= 0;
        end else begin
            hornRun <= hornRun + 1;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    AST_HORN_CAUSE: assert property ($rose(horn) |->
        $past(switches.doorOpen && !switches.parkBrakeSet, 2))
        else $error("horn rose without door open and brake released");
    // one second of slack covers the free-running tick phase
    AST_HORN_BOUND: assert property (hornRun <= 181 * TICK_PERIOD)
        else $error("horn ran past the longest duration");
    AST_PEDAL_QUIET: assert property (
        horn && switches.brakePedal |-> ##[1:2] !horn)
        else $error("horn kept sounding after a pedal press");
    AST_PEDAL_HOLD: assert property (
        switches.brakePedal [*3] |-> !horn)
        else $error("horn sounded while the pedal was held");
    AST_ALARM_CLEAR: assert property (
        (switches.ignitionOn && switches.parkBrakeSet) [*2] |-> ##1 !horn)
        else $error("horn sounded with ignition on and brake set");
    AST_LAMP_IGN: assert property (
        switches.ignitionOn [*3] |-> !buzzer)
        else $error("buzzer sounded with the vehicle on");
    AST_LAMP_DARK: assert property (
        !(switches.headlights || switches.parkLights) [*3] |-> !buzzer)
        else $error("buzzer sounded with all lamps off");
    AST_DOOR_BUZZ: assert property (
        buzzer && lampHold && $past(lampHold) |=> buzzer)
        else $error("continuous buzz dropped with the door open");
    AST_RESET_QUIET: assert property ($past(rst) |-> !horn && !buzzer)
        else $error("sounder active straight after reset");
endmodule
bind cwal_alarm_logic cwal_alarm_chk #(.TICK_PERIOD(TICK_PERIOD)) chk_u (
    .clock(clock), .rst(rst), .switches(switches), .horn(horn),
    .buzzer(buzzer));
`default_nettype wire

// *** bench/cwal_vehicle_model.sv ***
// vehicle side: switch contacts and an ear counting buzzer beeps
// assumes the bench sets wanted switch positions just after an edge
`timescale 1ns/100ps
`default_nettype none
module cwal_vehicle_model
    import cwal_pkg::*;
(
    // clock
    input  wire logic              clock,
    // wanted switch positions and count clear
    input  wire cwal_switches_type wantSwitches,
    input  wire logic              clearCount,
    // buzzer from the block
    input  wire logic              buzzer,
    // switch levels and beeps heard
    output var cwal_switches_type  switches,
    output var logic [7:0]         beepCount
);
    logic lastBuzzer;
    // contacts settle one edge late, so the block never sees a mid-edge change
    initial switches = 6'h10;
    always @(posedge clock) switches <= wantSwitches;
    // each buzzer onset counts as one beep heard in the cab
    always @(posedge clock) begin
        lastBuzzer <= buzzer;
        if (clearCount) begin
            beepCount <= 8'h00;
        end else if (buzzer && !lastBuzzer) begin
            beepCount <= beepCount + 8'h01;
        end
    end
endmodule
`default_nettype wire

// *** bench/cwal_alarm_logic_tb_top.sv ***
// self-checking bench for the cab warning alarm block
// assumes apb register map and state encodings of the package
`timescale 1ns/100ps
`default_nettype none
module cwal_alarm_logic_tb_top;
    import cwal_pkg::*;
    localparam int TICK = 10;
    logic              clock = 1'b0;
    logic              rst = 1'b1;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [7:0]        paddr = 8'h00;
    logic [31:0]       pwdata = 32'h0000_0000;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              horn;
    logic              buzzer;
    logic              irq;
    logic              clearCount = 1'b0;
    logic [7:0]        beepCount;
    cwal_switches_type wantSw = 6'h10;
    cwal_switches_type switches;
    logic [64:0]       expQ [$];
    int                fails = 0;
    int                num_checks = 0;
    int                cycles = 0;
    int                seed = 32'hc991;
    cwal_switches_type lampSw [4] = '{6'h12, 6'h11, 6'h12, 6'h32};
    logic [1:0]        lampCtl [4] = '{2'h3, 2'h3, 2'h1, 2'h3};
    logic [7:0]        lampBeeps [4] = '{8'h05, 8'h05, 8'h00, 8'h00};

    cwal_alarm_logic #(.TICK_PERIOD(TICK), .BEEP_ON(4), .BEEP_OFF(4)) dut_u (
        .clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .switches(switches),
        .horn(horn), .buzzer(buzzer), .irq(irq));
    cwal_vehicle_model model_u (
        .clock(clock), .wantSwitches(wantSw), .clearCount(clearCount),
        .buzzer(buzzer), .switches(switches), .beepCount(beepCount));

    always #2 clock = ~clock;

    task automatic conclude();
        // a read that never completed is a mismatch too
        if (expQ.size() != 0) begin
            fails++;
            $display("ERROR %0t reads left unanswered", $time);
        end
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic cmpRead(input logic [32:0] got, input logic [64:0] e);
        num_checks++;
        if ({got[32], got[31:0] & e[63:32]}
            !== {e[64], e[31:0] & e[63:32]}) begin
            fails++;
            $display("ERROR %0t read %h expected %h", $time, got,
                     {e[64], e[31:0]});
        end
    endtask
    task automatic chkPin(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t output %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; the request stands until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        // only the bench timeout ends a wait for the slave
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        psel <= 1'b0;
        penable <= 1'b0;
        // step off the edge so later looks see settled outputs
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m, input logic err);
        expQ.push_back({err, m, e});
        apb(1'b0, a, 32'h0000_0000);
    endtask
    task automatic setSw(input cwal_switches_type s);
        @(posedge clock);
        wantSw <= s;
    endtask
    // the extra 1 ns lets the edge's updates land before any look
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // read results come off the queue in the order they were asked for
    always @(posedge clock) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (expQ.size() == 0) begin
                fails++;
                $display("ERROR %0t read with nothing expected", $time);
            end else begin
                cmpRead({pslverr, prdata}, expQ.pop_front());
            end
        end
    end
    // a hang costs one mismatch and ends the run
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            conclude();
        end
    end

    initial begin
        int          i;
        logic [7:0]  v;
        logic [7:0]  s;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        // defaults, an unmapped word, clamping of random settings
        rd(ADDR_CONTROL, 32'h0000_0003, 32'hffff_ffff, 1'b0);
        rd(ADDR_DURATION, 32'h0000_003c, 32'hffff_ffff, 1'b0);
        rd(ADDR_SUSPEND, 32'h0000_000a, 32'hffff_ffff, 1'b0);
        wr(8'h18, 32'h0000_00ff);
        rd(8'h18, 32'h0000_0000, 32'hffff_ffff, 1'b1);
        for (i = 0; i < 5; i++) begin
            v = 8'($random(seed));
            wr(ADDR_DURATION, {24'h00_0000, v});
            s = (v > DURATION_MAX) ? DURATION_MAX : v;
            rd(ADDR_DURATION, {24'h00_0000, s}, 32'hffff_ffff, 1'b0);
            wr(ADDR_SUSPEND, {24'h00_0000, v});
            s = (v > SUSPEND_MAX) ? SUSPEND_MAX : v;
            rd(ADDR_SUSPEND, {24'h00_0000, s - s % SUSPEND_STEP},
               32'hffff_ffff, 1'b0);
        end
        // alarm runs out its duration; only the timeout event is unmasked
        wr(ADDR_IRQ_MASK, 32'h0000_0002);
        wr(ADDR_DURATION, 32'h0000_0003);
        setSw(6'h00);
        cyc(20);
        chkPin({7'h00, horn}, 8'h00);
        setSw(6'h04);
        cyc(6);
        rd(ADDR_STATUS, 32'h0000_0201, 32'h0000_0f01, 1'b0);
        chkPin({7'h00, irq}, 8'h00);
        cyc(40);
        rd(ADDR_STATUS, 32'h0000_0800, 32'h0000_0f01, 1'b0);
        chkPin({7'h00, irq}, 8'h01);
        rd(ADDR_IRQ_STAT, 32'h0000_0003, 32'h0000_0003, 1'b0);
        wr(ADDR_IRQ_STAT, 32'h0000_000f);
        cyc(2);
        chkPin({7'h00, irq}, 8'h00);
        setSw(6'h30);
        cyc(4);
        rd(ADDR_STATUS, 32'h0000_0100, 32'h0000_0f01, 1'b0);
        // pedal silences, suspends about ten seconds, then the horn resumes
        wr(ADDR_DURATION, 32'h0000_0014);
        wr(ADDR_SUSPEND, 32'h0000_000a);
        setSw(6'h04);
        cyc(6);
        chkPin({7'h00, horn}, 8'h01);
        setSw(6'h0c);
        cyc(3);
        chkPin({7'h00, horn}, 8'h00);
        setSw(6'h04);
        cyc(60);
        chkPin({7'h00, horn}, 8'h00);
        cyc(70);
        chkPin({7'h00, horn}, 8'h01);
        setSw(6'h30);
        cyc(4);
        chkPin({7'h00, horn}, 8'h00);
        // ignition on: only triggers once the key-off need is cleared
        setSw(6'h24);
        cyc(10);
        chkPin({7'h00, horn}, 8'h00);
        wr(ADDR_CONTROL, 32'h0000_0002);
        cyc(6);
        chkPin({7'h00, horn}, 8'h01);
        setSw(6'h30);
        cyc(4);
        chkPin({7'h00, horn}, 8'h00);
        // lamp reminder cases: beeps counted with the door closed
        wr(ADDR_IRQ_MASK, 32'h0000_0008);
        for (i = 0; i < 4; i++) begin
            wr(ADDR_CONTROL, {30'h0000_0000, lampCtl[i]});
            clearCount <= 1'b1;
            setSw(lampSw[i]);
            clearCount <= 1'b0;
            cyc(120);
            chkPin(beepCount, lampBeeps[i]);
            setSw(6'h10);
            cyc(4);
        end
        rd(ADDR_IRQ_STAT, 32'h0000_000d, 32'h0000_000f, 1'b0);
        chkPin({7'h00, irq}, 8'h01);
        // door open with the lamps on buzzes without a break
        setSw(6'h16);
        cyc(4);
        chkPin({7'h00, buzzer}, 8'h01);
        cyc(40);
        chkPin({7'h00, buzzer}, 8'h01);
        setSw(6'h10);
        cyc(4);
        chkPin({7'h00, buzzer}, 8'h00);
        // reset in mid-alarm quiets the horn and restores the duration default
        setSw(6'h04);
        cyc(6);
        chkPin({7'h00, horn}, 8'h01);
        @(posedge clock);
        rst <= 1'b1;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        cyc(1);
        chkPin({7'h00, horn}, 8'h00);
        rd(ADDR_DURATION, 32'h0000_003c, 32'hffff_ffff, 1'b0);
        rd(ADDR_STATUS, 32'h0000_0201, 32'h0000_0f01, 1'b0);
        conclude();
    end
endmodule
`default_nettype wire
